// >>> shared/ldd_pkg.sv
package ldd_pkg;

  // Clock and timing
  localparam int CLK_MHZ         = 100;
  localparam int T_GS_START_US   = 12000;
  localparam int T_GS_RUN_US     = 1000;
  localparam int T_GATE_HIGH_US  = 1000;
  localparam int GS_START_CYC    = T_GS_START_US * CLK_MHZ;
  localparam int GS_RUN_CYC      = T_GS_RUN_US * CLK_MHZ;
  localparam int GATE_HIGH_CYC   = T_GATE_HIGH_US * CLK_MHZ;
  localparam int TMR_W           = 21;

  // Serial frame layout: addr[15:9], write[8], data[7:0]
  localparam int FRAME_BITS      = 16;
  localparam int ADDR_MSB        = 15;
  localparam int ADDR_LSB        = 9;
  localparam int WRITE_BIT       = 8;
  localparam int CNT_W           = 8;

  // Register addresses
  localparam logic [6:0] ADDR_FUNC_CTRL = 7'h00;
  localparam logic [6:0] ADDR_REFRESH   = 7'h06;
  localparam logic [6:0] ADDR_HEADROOM  = 7'h35;
  localparam logic [6:0] ADDR_DIMNVM    = 7'h36;
  localparam logic [6:0] ADDR_OPSTAT    = 7'h37;

  // Field positions
  localparam int CLR_FAULTS_BIT  = 7;
  localparam int OP_SUPPLY_OK    = 7;
  localparam int OP_FRAME_ERR    = 6;
  localparam int OP_OVERTEMP     = 5;
  localparam int OP_GS_FAULT     = 4;
  localparam int OP_GS_GOOD      = 3;
  localparam int OP_TGT_LSB      = 0;
  localparam int DN_NVM_REJECT   = 4;
  localparam int DN_NVM_DONE     = 3;
  localparam int DN_TOGGLE_LSB   = 0;
  localparam int HC_LIVE_LSB     = 3;
  localparam int HC_HR_LSB       = 0;
  localparam int RF_REQ_LSB      = 0;

  // Reset values
  localparam logic [7:0]  REG_RST  = 8'h00;
  localparam logic [15:0] RESP_RST = 16'h0000;

  typedef struct packed {
    logic       vin_ok;
    logic       overtemp;
    logic       gs_at_target;
    logic       chip_en;
    logic       csn_n;
    logic [1:0] dim;
    logic [1:0] reached;
    logic [1:0] hr_low;
    logic [1:0] ch_on;
    logic [1:0] gate_on;
  } ldd_pin_s;

  typedef struct packed {
    ldd_pin_s                  sync1;
    ldd_pin_s                  sync2;
    logic                      csn_prev;
    logic [1:0]                dim_prev;
    logic                      frame_err;
    logic                      overtemp;
    logic                      gs_fault;
    logic                      gs_good;
    logic                      gs_starting;
    logic [TMR_W-1:0]          gs_tmr;
    logic [1:0]                tgt_latched;
    logic [1:0]                live;
    logic [1:0]                hr_flag;
    logic [1:0]                hr_sample;
    logic [1:0]                toggle;
    logic [1:0][TMR_W-1:0]     gate_hi_tmr;
    logic [1:0]                refresh_req;
    logic                      clr_faults;
    logic                      nvm_reject;
    logic                      nvm_done;
    logic [CNT_W-1:0]          start_cnt;
    logic [FRAME_BITS-1:0]     resp;
  } ldd_core_s;

  typedef struct packed {
    logic [CNT_W-1:0]          cnt;
    logic [FRAME_BITS-1:0]     shift;
  } ldd_link_s;

endpackage : ldd_pkg

// >>> core/ldd_diag.sv
`timescale 1ns/1ps

module ldd_diag
  import ldd_pkg::*;
#(
  parameter int GS_START_LIMIT  = GS_START_CYC,
  parameter int GS_RUN_LIMIT    = GS_RUN_CYC,
  parameter int GATE_HIGH_LIMIT = GATE_HIGH_CYC
) (
  input  wire logic       CLK,
  input  wire logic       RESET,
  input  wire logic       SCK,
  input  wire logic       CSN_N,
  input  wire logic       MOSI,
  output logic            MISO,
  output logic            MISO_OE,
  input  wire logic       VIN_ABOVE_UV,
  input  wire logic       OVERTEMP_DET,
  input  wire logic       GS_AT_TARGET,
  input  wire logic       CHIP_EN,
  input  wire logic [1:0] DIM_IN,
  input  wire logic [1:0] CURRENT_AT_TARGET,
  input  wire logic [1:0] HEADROOM_LOW,
  input  wire logic [1:0] CH_ON,
  input  wire logic [1:0] GATE_IS_HIGH,
  input  wire logic       NVM_REJECT,
  input  wire logic       NVM_DONE,
  output logic            GS_REG_EN,
  output logic            GATE_DRV_EN,
  output logic [1:0]      GATE_SWITCH_EN,
  output logic            LED_V_UPDATE_EN
);

  ldd_core_s r_r;
  ldd_core_s r_nxt;
  ldd_link_s l_r;
  ldd_link_s l_nxt;

  ldd_pin_s         pins;
  logic [7:0]       op_stat;
  logic [7:0]       dn_stat;
  logic [7:0]       hc_stat;
  logic [CNT_W-1:0] frame_len;
  logic [CNT_W-1:0] bit_idx;
  logic [15:0]      word;
  logic [6:0]       addr;
  logic             is_write;
  logic [7:0]       wdata;

  always_comb begin
    pins.vin_ok       = VIN_ABOVE_UV;
    pins.overtemp     = OVERTEMP_DET;
    pins.gs_at_target = GS_AT_TARGET;
    pins.chip_en      = CHIP_EN;
    pins.csn_n        = CSN_N;
    pins.dim          = DIM_IN;
    pins.reached      = CURRENT_AT_TARGET;
    pins.hr_low       = HEADROOM_LOW;
    pins.ch_on        = CH_ON;
    pins.gate_on      = GATE_IS_HIGH;
  end

  // Link side: samples MOSI on rising SCK; counter clears only on RESET so the
  // core can measure frame length by difference without a reset race.
  always_comb begin
    l_nxt = l_r;
    if (!CSN_N) begin
      l_nxt.cnt   = l_r.cnt + 1'b1;
      l_nxt.shift = {l_r.shift[FRAME_BITS-2:0], MOSI};
    end
  end

  always_ff @(posedge SCK or posedge RESET) begin
    if (RESET) begin
      l_r <= '0;
    end else begin
      l_r <= l_nxt;
    end
  end

  // Response word is static in the core during a frame
  assign bit_idx = l_r.cnt - r_r.start_cnt;
  assign MISO    = r_r.resp[4'hF - bit_idx[3:0]];
  assign MISO_OE = ~CSN_N;

  // Status views
  always_comb begin
    op_stat                    = REG_RST;
    op_stat[OP_SUPPLY_OK]      = r_r.sync2.vin_ok;
    op_stat[OP_FRAME_ERR]      = r_r.frame_err;
    op_stat[OP_OVERTEMP]       = r_r.overtemp;
    op_stat[OP_GS_FAULT]       = r_r.gs_fault;
    op_stat[OP_GS_GOOD]        = r_r.gs_good;
    op_stat[OP_TGT_LSB +: 2]   = r_r.tgt_latched;
    dn_stat                    = REG_RST;
    dn_stat[DN_NVM_REJECT]     = r_r.nvm_reject;
    dn_stat[DN_NVM_DONE]       = r_r.nvm_done;
    dn_stat[DN_TOGGLE_LSB +: 2] = r_r.toggle;
    hc_stat                    = REG_RST;
    hc_stat[HC_LIVE_LSB +: 2]  = r_r.live;
    hc_stat[HC_HR_LSB +: 2]    = r_r.hr_flag;
  end

  assign frame_len = l_r.cnt - r_r.start_cnt;
  assign word      = l_r.shift;
  assign addr      = word[ADDR_MSB:ADDR_LSB];
  assign is_write  = word[WRITE_BIT];
  assign wdata     = word[7:0];

  always_comb begin
    logic       frame_end;
    logic       bad;
    logic       wr_ok;
    logic [7:0] rdata;
    logic       supply_ok;
    logic       reg_on;
    logic       ot_rise;
    logic [1:0] dim_fall;
    logic [1:0] hr_event;
    logic [1:0] monitored;
    logic       wr_op;
    logic       wr_dn;
    logic       wr_hc;
    frame_end = 1'b0;
    bad       = 1'b0;
    wr_ok     = 1'b0;
    rdata     = REG_RST;
    wr_op     = 1'b0;
    wr_dn     = 1'b0;
    wr_hc     = 1'b0;

    r_nxt             = r_r;
    r_nxt.sync1       = pins;
    r_nxt.sync2       = r_r.sync1;
    r_nxt.csn_prev    = r_r.sync2.csn_n;
    r_nxt.dim_prev    = r_r.sync2.dim;
    r_nxt.refresh_req = 2'b00;
    r_nxt.clr_faults  = 1'b0;

    supply_ok = r_r.sync2.vin_ok;
    dim_fall  = r_r.dim_prev & ~r_r.sync2.dim;

    // Frame start and end seen on synchronised chip select
    if (r_r.csn_prev && !r_r.sync2.csn_n) begin
      r_nxt.start_cnt = l_r.cnt;
    end
    if (!r_r.csn_prev && r_r.sync2.csn_n && frame_len != '0) begin
      frame_end = 1'b1;
    end

    if (frame_end) begin
      unique case (addr)
        ADDR_FUNC_CTRL: rdata = REG_RST;
        ADDR_REFRESH:   rdata = REG_RST;
        ADDR_HEADROOM:  rdata = hc_stat;
        ADDR_DIMNVM:    rdata = dn_stat;
        ADDR_OPSTAT:    rdata = op_stat;
        default:        bad = 1'b1;
      endcase
      if (frame_len[3:0] != 4'h0) begin
        bad = 1'b1;
      end
      wr_ok = is_write && !bad;
      if (bad) begin
        // Error answer already shows the error it reports
        r_nxt.resp = {op_stat | (8'h01 << OP_FRAME_ERR), dn_stat};
      end else begin
        r_nxt.resp = {op_stat, rdata};
      end
      if (wr_ok) begin
        unique case (addr)
          ADDR_FUNC_CTRL: r_nxt.clr_faults = wdata[CLR_FAULTS_BIT];
          ADDR_REFRESH:   r_nxt.refresh_req = wdata[RF_REQ_LSB +: 2];
          ADDR_HEADROOM:  wr_hc = 1'b1;
          ADDR_DIMNVM:    wr_dn = 1'b1;
          ADDR_OPSTAT:    wr_op = 1'b1;
          default:        wr_ok = 1'b0;
        endcase
      end
    end

    // Frame error: a new error outranks the clearing write
    if (wr_op) begin
      r_nxt.frame_err = 1'b0;
    end
    if (bad) begin
      r_nxt.frame_err = 1'b1;
    end

    // Overtemperature latch
    ot_rise = r_r.sync2.overtemp && !r_r.overtemp;
    if (r_r.clr_faults) begin
      r_nxt.overtemp = 1'b0;
    end
    if (r_r.sync2.overtemp) begin
      r_nxt.overtemp = 1'b1;
    end

    // Gate supply regulator and watchdog
    reg_on = supply_ok && r_r.sync2.chip_en && !r_r.overtemp && !r_r.gs_fault;
    if (!reg_on || r_r.sync2.gs_at_target) begin
      r_nxt.gs_tmr = '0;
    end else begin
      r_nxt.gs_tmr = r_r.gs_tmr + 1'b1;
    end
    if (r_r.sync2.gs_at_target && reg_on) begin
      r_nxt.gs_good     = 1'b1;
      r_nxt.gs_starting = 1'b0;
    end
    if (!reg_on) begin
      r_nxt.gs_good = 1'b0;
    end
    if (!r_r.sync2.chip_en) begin
      r_nxt.gs_starting = 1'b1;
    end
    if (r_r.clr_faults || !r_r.sync2.chip_en) begin
      r_nxt.gs_fault = 1'b0;
    end
    if (reg_on && !r_r.sync2.gs_at_target &&
        ((r_r.gs_starting && r_r.gs_tmr >= TMR_W'(GS_START_LIMIT - 1)) ||
         (!r_r.gs_starting && r_r.gs_tmr >= TMR_W'(GS_RUN_LIMIT - 1)))) begin
      r_nxt.gs_fault = 1'b1;
      r_nxt.gs_good  = 1'b0;
    end
    if (ot_rise && r_r.gs_good) begin
      r_nxt.gs_fault = 1'b1;
    end

    // Per-channel current reached, headroom and toggle tracking
    monitored = r_r.sync2.ch_on & {2{supply_ok}};
    hr_event  = monitored & r_r.sync2.hr_low & ~r_r.hr_sample;
    for (int c = 0; c < 2; c++) begin
      if (monitored[c]) begin
        r_nxt.hr_sample[c] = r_r.sync2.hr_low[c];
      end
      if (wr_hc) begin
        r_nxt.hr_flag[c] = 1'b0;
      end
      if (r_r.hr_sample[c] || (monitored[c] && r_r.sync2.hr_low[c])) begin
        r_nxt.hr_flag[c] = 1'b1;
      end

      if (r_r.sync2.gate_on[c] && r_r.sync2.dim[c]) begin
        if (r_r.gate_hi_tmr[c] != TMR_W'(GATE_HIGH_LIMIT)) begin
          r_nxt.gate_hi_tmr[c] = r_r.gate_hi_tmr[c] + 1'b1;
        end
      end else begin
        r_nxt.gate_hi_tmr[c] = '0;
      end

      if (r_r.sync2.reached[c] && r_r.sync2.dim[c]) begin
        r_nxt.live[c] = 1'b1;
      end
      if (dim_fall[c] || !supply_ok || r_r.refresh_req[c] ||
          r_r.gate_hi_tmr[c] >= TMR_W'(GATE_HIGH_LIMIT - 1)) begin
        r_nxt.live[c] = 1'b0;
      end

      if (dim_fall[c] || r_r.refresh_req[c]) begin
        r_nxt.tgt_latched[c] = r_r.live[c];
      end
      if (!supply_ok || hr_event[c]) begin
        r_nxt.tgt_latched[c] = 1'b0;
      end

      if (wr_dn) begin
        r_nxt.toggle[c] = 1'b0;
      end
      if (r_r.dim_prev[c] != r_r.sync2.dim[c]) begin
        r_nxt.toggle[c] = 1'b1;
      end
    end

    // NVM result flags, event wins over the clearing write
    if (wr_dn) begin
      r_nxt.nvm_reject = 1'b0;
      r_nxt.nvm_done   = 1'b0;
    end
    if (NVM_REJECT) begin
      r_nxt.nvm_reject = 1'b1;
    end
    if (NVM_DONE) begin
      r_nxt.nvm_done = 1'b1;
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      r_r             <= '0;
      r_r.sync1.csn_n <= 1'b1;
      r_r.sync2.csn_n <= 1'b1;
      r_r.csn_prev    <= 1'b1;
      r_r.gs_starting <= 1'b1;
      r_r.resp        <= RESP_RST;
    end else begin
      r_r <= r_nxt;
    end
  end

  // Outputs from state flops only
  always_comb begin
    GS_REG_EN       = r_r.sync2.vin_ok && r_r.sync2.chip_en &&
                      !r_r.overtemp && !r_r.gs_fault;
    GATE_DRV_EN     = GS_REG_EN && r_r.gs_good;
    GATE_SWITCH_EN  = {2{GATE_DRV_EN}} & r_r.sync2.dim &
                      ~(r_r.sync2.ch_on & r_r.sync2.hr_low);
    // Tied to the driver enable so a stale good flag cannot leak one cycle
    LED_V_UPDATE_EN = GATE_DRV_EN;
  end

endmodule : ldd_diag

// >>> tb/ldd_diag_assertions.sv
`timescale 1ns/1ps
module ldd_diag_chk (
  input wire logic       CLK,
  input wire logic       RESET,
  input wire logic       CSN_N,
  input wire logic       MISO_OE,
  input wire logic       VIN_ABOVE_UV,
  input wire logic       OVERTEMP_DET,
  input wire logic [1:0] DIM_IN,
  input wire logic [1:0] HEADROOM_LOW,
  input wire logic [1:0] CH_ON,
  input wire logic       GS_REG_EN,
  input wire logic       GATE_DRV_EN,
  input wire logic [1:0] GATE_SWITCH_EN,
  input wire logic       LED_V_UPDATE_EN
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);
  // Four samples cover the two-flop input sync and, for overtemperature, the flag register
  a_uv_gates_off: assert property (!VIN_ABOVE_UV [*4] |-> !GS_REG_EN && GATE_SWITCH_EN == 2'b00)
    else $error("gates active under low supply");
  a_uv_meas_frozen: assert property ($fell(VIN_ABOVE_UV) ##1 !VIN_ABOVE_UV [*3] |-> !LED_V_UPDATE_EN)
    else $error("measurement updates under low supply");
  a_meas_needs_good: assert property (LED_V_UPDATE_EN |-> GATE_DRV_EN)
    else $error("measurement updates without good gate supply");
  a_drv_needs_reg: assert property (GATE_DRV_EN |-> GS_REG_EN)
    else $error("gate driver on with regulator off");
  a_ot_shuts_gates: assert property (OVERTEMP_DET [*4] |-> !GS_REG_EN && !GATE_DRV_EN)
    else $error("gate supply on during overtemperature");
  a_switch_needs_drv: assert property ($rose(|GATE_SWITCH_EN) |-> GATE_DRV_EN)
    else $error("switching without gate driver");
  a_hr_cuts_ch1: assert property ((HEADROOM_LOW[0] && CH_ON[0]) [*4] |-> !GATE_SWITCH_EN[0])
    else $error("channel 1 switches with low headroom");
  a_hr_cuts_ch2: assert property ((HEADROOM_LOW[1] && CH_ON[1]) [*4] |-> !GATE_SWITCH_EN[1])
    else $error("channel 2 switches with low headroom");
  a_switch_resumes: assert property (
    (!HEADROOM_LOW[1] && CH_ON[1] && DIM_IN[1] && GATE_DRV_EN) [*4] |-> GATE_SWITCH_EN[1])
    else $error("channel 2 does not resume switching");
  a_oe_tracks_select: assert property (MISO_OE == !CSN_N)
    else $error("serial output enable off select");
  c_drv_on: cover property (GATE_DRV_EN && GATE_SWITCH_EN == 2'b10);
  c_drv_off: cover property ($fell(GATE_DRV_EN));
  c_frame: cover property ($rose(MISO_OE));
endmodule : ldd_diag_chk

bind ldd_diag ldd_diag_chk u_chk (
  .CLK(CLK), .RESET(RESET), .CSN_N(CSN_N), .MISO_OE(MISO_OE),
  .VIN_ABOVE_UV(VIN_ABOVE_UV), .OVERTEMP_DET(OVERTEMP_DET), .DIM_IN(DIM_IN),
  .HEADROOM_LOW(HEADROOM_LOW), .CH_ON(CH_ON), .GS_REG_EN(GS_REG_EN),
  .GATE_DRV_EN(GATE_DRV_EN), .GATE_SWITCH_EN(GATE_SWITCH_EN),
  .LED_V_UPDATE_EN(LED_V_UPDATE_EN)
);

// >>> tb/ldd_spi_host.sv
`timescale 1ns/1ps
module ldd_spi_host (
  output logic      SCK,
  output logic      CSN_N,
  output logic      MOSI,
  input  wire logic MISO
);
  initial begin
    SCK   = 1'b0;
    CSN_N = 1'b1;
    MOSI  = 1'b0;
  end
  // Clock runs only inside a frame; n below 16 makes a deliberately short frame
  task automatic xfer(input int n, input logic [15:0] w, output logic [15:0] r);
    r     = 16'h0000;
    CSN_N = 1'b0;
    #60;
    for (int i = n - 1; i >= 0; i--) begin
      MOSI = w[i];
      r    = {r[14:0], MISO};
      #7.5 SCK = 1'b1;
      #7.5 SCK = 1'b0;
    end
    #60 CSN_N = 1'b1;
    // Released line must not keep the last bit
    MOSI = ~MOSI;
    #150;
  endtask : xfer
endmodule : ldd_spi_host

// >>> tb/ldd_diag_tb.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin error_cnt++; $display("[ERR] %s expected %h seen %h", nm, ex, got); end end
module ldd_diag_tb
  import ldd_pkg::*;
;
  logic        clk, rst, vin, ot, gs, en, nvm_rej, nvm_done;
  logic [1:0]  dim, cur, hr, chon, gate_hi;
  logic [15:0] r, prev;
  wire         sck, csn_n, mosi, miso, miso_oe, drv_en, led_upd;
  int          error_cnt, n_compared;

  ldd_spi_host host (.SCK(sck), .CSN_N(csn_n), .MOSI(mosi), .MISO(miso));
  ldd_diag #(.GS_START_LIMIT(50), .GS_RUN_LIMIT(20), .GATE_HIGH_LIMIT(20)) dut (
    .CLK(clk), .RESET(rst), .SCK(sck), .CSN_N(csn_n), .MOSI(mosi), .MISO(miso),
    .MISO_OE(miso_oe), .VIN_ABOVE_UV(vin), .OVERTEMP_DET(ot), .GS_AT_TARGET(gs),
    .CHIP_EN(en), .DIM_IN(dim), .CURRENT_AT_TARGET(cur), .HEADROOM_LOW(hr),
    .CH_ON(chon), .GATE_IS_HIGH(gate_hi), .NVM_REJECT(nvm_rej), .NVM_DONE(nvm_done),
    .GS_REG_EN(), .GATE_DRV_EN(drv_en), .GATE_SWITCH_EN(), .LED_V_UPDATE_EN(led_upd)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : give_verdict

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt

  // Answer to a read arrives in the following frame
  task automatic rd(input logic [6:0] a, input logic [15:0] ex);
    host.xfer(16, {a, 1'b0, 8'h00}, prev);
    host.xfer(16, {ADDR_OPSTAT, 1'b0, 8'h00}, r);
    `CHK("read word", ex, r)
  endtask : rd

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    host.xfer(16, {a, 1'b1, d}, prev);
  endtask : wr

  initial begin
    #100000;
    error_cnt++;
    give_verdict();
  end

  initial begin
    {rst, vin, gs, en, chon} = {1'b1, 1'b1, 1'b1, 1'b1, 2'b11};
    {ot, nvm_rej, nvm_done, dim, cur, hr, gate_hi} = '0;
    error_cnt = 0;
    n_compared = 0;
    wt(3);
    rst <= 1'b0;
    wt(10);
    `CHK("gate driver on", 1'b1, drv_en)
    `CHK("measure on", 1'b1, led_upd)
    rd(ADDR_OPSTAT, 16'h8888);
    wr(7'h10, 8'h00);
    rd(ADDR_OPSTAT, 16'hC8C8);
    `CHK("error answer", 16'hC800, prev)
    wr(ADDR_OPSTAT, 8'h5A);
    rd(ADDR_OPSTAT, 16'h8888);
    host.xfer(12, 16'h0000, prev);
    rd(ADDR_OPSTAT, 16'hC8C8);
    `CHK("short frame answer", 16'hC800, prev)
    wr(ADDR_OPSTAT, 8'h00);
    rd(7'h20, 16'hC800);
    wr(ADDR_OPSTAT, 8'h00);
    @(posedge clk);
    {dim, cur, nvm_rej, nvm_done} <= {2'b01, 2'b01, 1'b1, 1'b1};
    @(posedge clk);
    {nvm_rej, nvm_done} <= 2'b00;
    wt(10);
    rd(ADDR_DIMNVM, 16'h8819);
    rd(ADDR_HEADROOM, 16'h8808);
    {dim, cur} <= 4'b0000;
    wt(10);
    rd(ADDR_OPSTAT, 16'h8989);
    rd(ADDR_HEADROOM, 16'h8900);
    wr(ADDR_DIMNVM, 8'hFF);
    rd(ADDR_DIMNVM, 16'h8900);
    {dim, cur} <= 4'b1010;
    wt(10);
    cur <= 2'b00;
    wt(10);
    rd(ADDR_HEADROOM, 16'h8910);
    wr(ADDR_REFRESH, 8'h02);
    rd(ADDR_HEADROOM, 16'h8B00);
    rd(ADDR_REFRESH, 16'h8B00);
    hr <= 2'b11;
    wt(10);
    hr <= 2'b00;
    wt(10);
    rd(ADDR_HEADROOM, 16'h8803);
    wr(ADDR_HEADROOM, 8'h00);
    rd(ADDR_HEADROOM, 16'h8800);
    ot <= 1'b1;
    wt(10);
    `CHK("gate driver off", 1'b0, drv_en)
    `CHK("measure frozen", 1'b0, led_upd)
    rd(ADDR_OPSTAT, 16'hB0B0);
    ot <= 1'b0;
    wt(10);
    wr(ADDR_FUNC_CTRL, 8'h80);
    wt(60);
    rd(ADDR_OPSTAT, 16'h8888);
    gs <= 1'b0;
    wt(80);
    rd(ADDR_OPSTAT, 16'h9090);
    `CHK("fault measure frozen", 1'b0, led_upd)
    en <= 1'b0;
    wt(10);
    rd(ADDR_OPSTAT, 16'h8080);
    {en, gs} <= 2'b11;
    wt(10);
    vin <= 1'b0;
    wt(10);
    `CHK("uv driver off", 1'b0, drv_en)
    rd(ADDR_OPSTAT, 16'h0000);
    give_verdict();
  end
endmodule : ldd_diag_tb
